// >>> hdl/memmap_defines.svh
// Constants for the system memory map decoder
`ifndef MEMMAP_DEFINES_SVH
`define MEMMAP_DEFINES_SVH

`define SYS_CLK_MHZ          200
`define FLASH_PIPE_MAX_MHZ   160
`define FLASH_NOPIPE_MAX_MHZ 36

`define READ_MODE_W          3
`define READ_MODE_RESET      3'h0
`define EXT_WIDTH_RESET      1'b0

`define EXT_BASE             32'h6000_0000
`define EXT_CS_SPAN          32'h0800_0000
`define EXT_CS_COUNT         4
`define EXT_LIMIT_16         32'h0200_0000
`define EXT_LIMIT_8          32'h0100_0000

`define OVL_BASE             32'h0400_0000
`define OVL_SIZE             32'h0040_0000

`define FLASH_BANK_SIZE      32'h0008_0000
`define FLASH_BANKS_FULL     4
`define FLASH_BANKS_HALF     2
`define FLASH_ADDR_W         21

`define FRAME_COUNT          10
`define FRAME_4K             32'h0000_1000
`define FRAME_DBG_ROM_BASE   32'hFFA0_0000
`define FRAME_DMA_RAM_BASE   32'hFFF8_0000
`define FRAME_DMA_RAM_LAST   32'hFFF8_0FFF
`define FRAME_FLASH_REG_BASE 32'hFFF8_7000
`define FRAME_FLASH_REG_LAST 32'hFFF8_7FFF
`define FRAME_CENTRAL_BASE   32'hFFFF_E000
`define FRAME_CENTRAL_LAST   32'hFFFF_E0FF
`define FRAME_ERRSIG_BASE    32'hFFFF_F500
`define FRAME_ERRSIG_LAST    32'hFFFF_F5FF
`define FRAME_TICK_BASE      32'hFFFF_FC00
`define FRAME_TICK_LAST      32'hFFFF_FCFF

`define TGT_FLASH            0
`define TGT_EXT              1
`define TGT_FRAME0           2
`define TGT_W                12

`endif

// >>> hdl/memmap_pkg.sv
// Types shared by the memory map decoder
package memmap_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_FETCH = 4'h2,
        ST_RESP  = 4'h4,
        ST_BEAT2 = 4'h8
    } state_t;

    typedef enum logic [1:0] {
        CMD_READ    = 2'h0,
        CMD_WRITE   = 2'h1,
        CMD_PROGRAM = 2'h2,
        CMD_ERASE   = 2'h3
    } cmd_t;

    typedef enum logic [1:0] {
        SZ_BYTE  = 2'h0,
        SZ_HALF  = 2'h1,
        SZ_WORD  = 2'h2,
        SZ_DWORD = 2'h3
    } size_t;
endpackage

// >>> hdl/flash_sector_decode.sv
// Flash bank and sector decode
`timescale 1ns/1ps
`include "memmap_defines.svh"
module flash_sector_decode (
    // Flash-relative address
    input  wire logic [`FLASH_ADDR_W-1:0] addr,
    // Sector location
    output logic      [1:0]               bank,
    output logic      [3:0]               sector,
    output logic      [4:0]               index,
    output logic      [`FLASH_ADDR_W-1:0] base
);
    always_comb begin
        bank = addr[20:19];
        if (addr[20:19] != 2'h0) begin
            // Upper banks: four equal 128K sectors each
            sector = {2'h0, addr[18:17]};
            base   = {addr[20:17], 17'h0};
            index  = 5'(10 + 4 * (addr[20:19] - 1) + addr[18:17]);
        end else if (addr[18:15] < 4'h3) begin
            sector = {2'h0, addr[16:15]};   // 32K sectors
            base   = {addr[20:15], 15'h0};
            index  = {3'h0, addr[16:15]};
        end else if (addr[18:14] == 5'h06) begin
            sector = addr[13] ? 4'h4 : 4'h3; // 8K sectors 3 and 4
            base   = {addr[20:13], 13'h0};
            index  = addr[13] ? 5'h04 : 5'h03;
        end else if (addr[18:14] == 5'h07) begin
            sector = 4'h5;                  // 16K sector at 0x1C000
            base   = {addr[20:14], 14'h0};
            index  = 5'h05;
        end else if (!addr[18]) begin
            sector = {3'h3, addr[16]};      // 64K sectors
            base   = {addr[20:16], 16'h0};
            index  = {4'h3, addr[16]};
        end else begin
            sector = {3'h4, addr[17]};      // 128K sectors
            base   = {addr[20:17], 17'h0};
            index  = {4'h4, addr[17]};
        end
    end
endmodule // flash_sector_decode

// >>> hdl/frame_decode.sv
// Fixed system frame decode
`timescale 1ns/1ps
`include "memmap_defines.svh"
module frame_decode (
    // Bus address
    input  wire logic [31:0]             addr,
    // One bit per frame
    output logic      [`FRAME_COUNT-1:0] hit
);
    localparam logic [31:0] FB [`FRAME_COUNT] = '{
        `FRAME_DBG_ROM_BASE,
        `FRAME_DBG_ROM_BASE + `FRAME_4K,
        `FRAME_DBG_ROM_BASE + 2 * `FRAME_4K,
        `FRAME_DBG_ROM_BASE + 3 * `FRAME_4K,
        `FRAME_DBG_ROM_BASE + 4 * `FRAME_4K,
        `FRAME_DMA_RAM_BASE, `FRAME_FLASH_REG_BASE,
        `FRAME_CENTRAL_BASE, `FRAME_ERRSIG_BASE, `FRAME_TICK_BASE};
    localparam logic [31:0] FL [`FRAME_COUNT] = '{
        `FRAME_DBG_ROM_BASE + `FRAME_4K - 1,
        `FRAME_DBG_ROM_BASE + 2 * `FRAME_4K - 1,
        `FRAME_DBG_ROM_BASE + 3 * `FRAME_4K - 1,
        `FRAME_DBG_ROM_BASE + 4 * `FRAME_4K - 1,
        `FRAME_DBG_ROM_BASE + 5 * `FRAME_4K - 1,
        `FRAME_DMA_RAM_LAST, `FRAME_FLASH_REG_LAST,
        `FRAME_CENTRAL_LAST, `FRAME_ERRSIG_LAST, `FRAME_TICK_LAST};

    // Debug frames, DMA RAM, flash wrapper, central resource, error, tick
    for (genvar i = 0; i < `FRAME_COUNT; i++) begin : g_frame
        assign hit[i] = (addr >= FB[i]) && (addr <= FL[i]);
    end
endmodule // frame_decode

// >>> hdl/system_memory_map_decoder.sv
// System memory map decoder with flash read sequencing
`timescale 1ns/1ps
`include "memmap_defines.svh"
module system_memory_map_decoder #(
    parameter int CLK_MHZ    = `SYS_CLK_MHZ,
    parameter bit FULL_FLASH = 1'b1
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // Configuration
    input  wire logic                       read_mode_we,
    input  wire logic [`READ_MODE_W-1:0]    read_mode_in,
    input  wire logic                       ext_width_we,
    input  wire logic                       ext_width_8_in,
    input  wire logic                       overlay_redirect,
    // Request
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire logic [31:0]                req_addr,
    input  wire memmap_pkg::cmd_t           req_cmd,
    input  wire memmap_pkg::size_t          req_size,
    // Response
    output logic                            resp_valid,
    output logic                            resp_last,
    output logic                            resp_error,
    output logic [`TGT_W-1:0]               resp_target,
    output logic [1:0]                      resp_ext_cs,
    output logic [31:0]                     resp_offset,
    output logic [63:0]                     resp_data,
    // Flash array
    output logic                            flash_fetch_req,
    output logic                            flash_fetch_wide,
    output logic [`FLASH_ADDR_W-1:0]        flash_fetch_addr,
    input  wire logic                       flash_fetch_valid,
    input  wire logic [127:0]               flash_fetch_data,
    output logic                            flash_prog_req,
    output logic                            flash_prog_half,
    output logic [`FLASH_ADDR_W-1:0]        flash_prog_addr,
    output logic                            flash_erase_req,
    output logic [1:0]                      flash_erase_bank,
    output logic [3:0]                      flash_erase_sector,
    output logic [`FLASH_ADDR_W-1:0]        flash_erase_base,
    // Status
    output logic [`READ_MODE_W-1:0]         flash_read_control,
    output logic                            flash_pipelined,
    output logic                            flash_rate_ok,
    output logic                            ext_width_8
);
    localparam logic [31:0] FLASH_TOP = FULL_FLASH ?
        32'(`FLASH_BANKS_FULL) * `FLASH_BANK_SIZE :
        32'(`FLASH_BANKS_HALF) * `FLASH_BANK_SIZE;

    ////////////////////////////////////////////////////////////////////////
    // Configuration state

    logic [`READ_MODE_W-1:0] read_mode_reg;
    logic                    ext_width_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            read_mode_reg <= `READ_MODE_RESET;
        end else if (read_mode_we) begin
            read_mode_reg <= read_mode_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ext_width_reg <= `EXT_WIDTH_RESET;
        end else if (ext_width_we) begin
            ext_width_reg <= ext_width_8_in;
        end
    end

    assign flash_read_control = read_mode_reg;
    assign flash_pipelined    = (read_mode_reg != 3'h0);
    assign ext_width_8        = ext_width_reg;
    // Clock ceiling is a build-time fact, so only the mode choice moves it
    assign flash_rate_ok = flash_pipelined ?
        (CLK_MHZ <= `FLASH_PIPE_MAX_MHZ) :
        (CLK_MHZ <= `FLASH_NOPIPE_MAX_MHZ);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic [`FRAME_COUNT-1:0] frame_hit;
    logic [1:0]              sec_bank;
    logic [3:0]              sec_num;
    logic [4:0]              sec_index;
    logic [`FLASH_ADDR_W-1:0] sec_base;
    logic [31:0]             ext_rel;
    logic [31:0]             ext_off;
    logic                    flash_hit;
    logic                    ovl_hit;
    logic                    ext_hit;
    logic                    ext_in_limit;
    logic                    to_ext;
    logic                    is_flash;
    logic                    bad;
    logic [`TGT_W-1:0]       tgt_next;
    logic [31:0]             off_next;
    logic [1:0]              cs_next;

    frame_decode u_frames (
        .addr (req_addr),
        .hit  (frame_hit)
    );

    flash_sector_decode u_sectors (
        .addr   (req_addr[`FLASH_ADDR_W-1:0]),
        .bank   (sec_bank),
        .sector (sec_num),
        .index  (sec_index),
        .base   (sec_base)
    );

    // Half-size parts leave banks 2 and 3 unmapped
    assign flash_hit = (req_addr < FLASH_TOP);
    assign ovl_hit   = (req_addr >= `OVL_BASE) &&
                       (req_addr < `OVL_BASE + `OVL_SIZE);
    assign ext_hit   = (req_addr >= `EXT_BASE) &&
                       (req_addr < `EXT_BASE + `EXT_CS_COUNT * `EXT_CS_SPAN);
    assign ext_rel   = req_addr - `EXT_BASE;
    assign ext_off   = ext_rel & (`EXT_CS_SPAN - 32'h1);
    // Upper part of each chip select is dead for narrow memories
    assign ext_in_limit = ext_width_reg ? (ext_off < `EXT_LIMIT_8) :
                                          (ext_off < `EXT_LIMIT_16);
    // Redirected flash reads only; program and erase stay on the array
    assign to_ext   = flash_hit && overlay_redirect &&
                      (req_cmd == memmap_pkg::CMD_READ);
    assign is_flash = flash_hit && !to_ext;

    always_comb begin
        tgt_next = '0;
        off_next = req_addr;
        cs_next  = 2'h0;
        if (ovl_hit) begin
            tgt_next[`TGT_EXT] = 1'b1;
            off_next = req_addr - `OVL_BASE;
        end else if (to_ext) begin
            tgt_next[`TGT_EXT] = 1'b1;
        end else if (ext_hit) begin
            tgt_next[`TGT_EXT] = ext_in_limit;
            off_next = ext_off;
            cs_next  = ext_rel[28:27];
        end else if (is_flash) begin
            tgt_next[`TGT_FLASH] = 1'b1;
        end else begin
            tgt_next[`TGT_W-1:`TGT_FRAME0] = frame_hit;
            off_next = req_addr & (`FRAME_4K - 32'h1);
        end
    end

    // Unmapped, beyond the width limit, or a flash command on the wrong
    // space; program size must be word or halfword
    always_comb begin
        bad = (tgt_next == '0);
        if ((req_cmd == memmap_pkg::CMD_PROGRAM) ||
            (req_cmd == memmap_pkg::CMD_ERASE)) begin
            bad = !is_flash;
        end
        if (req_cmd == memmap_pkg::CMD_PROGRAM &&
            req_size != memmap_pkg::SZ_WORD &&
            req_size != memmap_pkg::SZ_HALF) begin
            bad = 1'b1;
        end
        if (is_flash && req_cmd == memmap_pkg::CMD_WRITE) begin
            bad = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    memmap_pkg::state_t state_reg;
    memmap_pkg::state_t state_next;
    logic               take;
    logic               fetch_next;
    logic               pipe_reg;

    assign take       = req_valid && req_ready;
    assign fetch_next = is_flash && !bad && (req_cmd == memmap_pkg::CMD_READ);

    always_comb begin
        case (state_reg)
            memmap_pkg::ST_IDLE: begin
                if (!take) begin
                    state_next = memmap_pkg::ST_IDLE;
                end else if (fetch_next) begin
                    state_next = memmap_pkg::ST_FETCH;
                end else begin
                    state_next = memmap_pkg::ST_RESP;
                end
            end
            memmap_pkg::ST_FETCH: begin
                state_next = flash_fetch_valid ? memmap_pkg::ST_RESP :
                                                 memmap_pkg::ST_FETCH;
            end
            memmap_pkg::ST_RESP: begin
                state_next = pipe_reg ? memmap_pkg::ST_BEAT2 :
                                        memmap_pkg::ST_IDLE;
            end
            default: begin
                state_next = memmap_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= memmap_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_ready       = (state_reg == memmap_pkg::ST_IDLE);
    assign resp_valid      = (state_reg == memmap_pkg::ST_RESP) ||
                             (state_reg == memmap_pkg::ST_BEAT2);
    assign resp_last       = (state_reg == memmap_pkg::ST_BEAT2) ||
                             ((state_reg == memmap_pkg::ST_RESP) && !pipe_reg);
    assign flash_fetch_req = (state_reg == memmap_pkg::ST_FETCH);

    ////////////////////////////////////////////////////////////////////////
    // Request capture

    always_ff @(posedge clk) begin
        if (!resetn) begin
            resp_error  <= 1'b0;
            resp_target <= '0;
            resp_offset <= 32'h0;
            resp_ext_cs <= 2'h0;
        end else if (take) begin
            resp_error  <= bad;
            resp_target <= bad ? '0 : tgt_next;
            resp_offset <= off_next;
            resp_ext_cs <= cs_next;
        end
    end

    // Mode is sampled per access so a change never splits a burst
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pipe_reg <= 1'b0;
        end else if (take) begin
            pipe_reg <= fetch_next && flash_pipelined;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flash_fetch_wide <= 1'b0;
            flash_fetch_addr <= '0;
        end else if (take && fetch_next) begin
            flash_fetch_wide <= flash_pipelined;
            // Wide fetch is 16-byte aligned, narrow one 8-byte aligned
            flash_fetch_addr <= flash_pipelined ?
                {req_addr[20:4], 4'h0} : {req_addr[20:3], 3'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [63:0] hold_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            resp_data <= 64'h0;
            hold_reg  <= 64'h0;
        end else if (flash_fetch_req && flash_fetch_valid) begin
            if (flash_fetch_wide) begin
                resp_data <= flash_fetch_data[127:64];
                hold_reg  <= flash_fetch_data[63:0];
            end else begin
                resp_data <= flash_fetch_data[63:0];
            end
        end else if (state_reg == memmap_pkg::ST_RESP && pipe_reg) begin
            resp_data <= hold_reg;
        end else if (take) begin
            resp_data <= 64'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program and erase commands

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flash_prog_req  <= 1'b0;
            flash_prog_half <= 1'b0;
            flash_prog_addr <= '0;
        end else begin
            flash_prog_req <= take && !bad &&
                              (req_cmd == memmap_pkg::CMD_PROGRAM);
            if (take) begin
                flash_prog_half <= (req_size == memmap_pkg::SZ_HALF);
                flash_prog_addr <= req_addr[`FLASH_ADDR_W-1:0];
            end
        end
    end

    // Erase always names a whole sector by its base
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flash_erase_req    <= 1'b0;
            flash_erase_bank   <= 2'h0;
            flash_erase_sector <= 4'h0;
            flash_erase_base   <= '0;
        end else begin
            flash_erase_req <= take && !bad &&
                               (req_cmd == memmap_pkg::CMD_ERASE);
            if (take) begin
                flash_erase_bank   <= sec_bank;
                flash_erase_sector <= sec_num;
                flash_erase_base   <= sec_base;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_wide_read;
        take && fetch_next && flash_pipelined;
    endsequence

    sequence s_two_beats;
        (resp_valid && !resp_last) ##1 (resp_valid && resp_last);
    endsequence
    property p_two_beats;
        s_wide_read |=> ##[0:19] (flash_fetch_req && flash_fetch_valid) ##1 s_two_beats;
    endproperty

    a_mode_reset: assert property (disable iff (1'b0)
        !resetn |=> (flash_read_control == 3'h0) && !flash_pipelined)
        else $error("read mode not cleared by reset");
    a_width_reset: assert property (disable iff (1'b0)
        !resetn |=> !ext_width_8)
        else $error("external width not 16 bits after reset");
    a_pipe_beats: assert property (p_two_beats)
        else $error("pipelined read did not return two words");
    a_ovl_route: assert property (take && ovl_hit |=>
        resp_target[`TGT_EXT] && resp_ext_cs == 2'h0 && resp_offset < `OVL_SIZE)
        else $error("overlay access not in chip select zero low window");
    a_ext16_limit: assert property (take && ext_hit && !ext_width_reg &&
        ext_off >= `EXT_LIMIT_16 |=> resp_error && resp_valid)
        else $error("16-bit external access beyond limit accepted");
    a_ext8_limit: assert property (take && ext_hit && ext_width_reg &&
        ext_off >= `EXT_LIMIT_8 |=> resp_error)
        else $error("8-bit external access beyond limit accepted");
    a_prog_size: assert property (flash_prog_req |->
        !resp_error && $past(req_size) inside {memmap_pkg::SZ_WORD,
        memmap_pkg::SZ_HALF})
        else $error("program of illegal size issued");
    a_erase_whole: assert property (take &&
        req_cmd == memmap_pkg::CMD_ERASE && !bad |=> flash_erase_req
        && flash_erase_base <= $past(req_addr[`FLASH_ADDR_W-1:0]))
        else $error("erase did not name a sector base");
    a_bank3_first: assert property (take && is_flash &&
        req_addr >= 32'h0018_0000 && req_addr <= 32'h0019_FFFF |->
        sec_bank == 2'h3 && sec_num == 4'h0 && sec_index == 5'd18)
        else $error("bank 3 first sector misdecoded");
    a_dma_frame: assert property (take && !bad && req_cmd ==
        memmap_pkg::CMD_READ && req_addr[31:12] == 20'hFFF80 |=>
        resp_target[`TGT_FRAME0 + 5] && resp_valid)
        else $error("DMA packet RAM frame not selected");
    a_unmapped_err: assert property (take && tgt_next == '0 |=>
        resp_valid && resp_error && resp_target == '0)
        else $error("unmapped access returned no error");
    a_rate_flag: assert property (flash_pipelined == $past(flash_pipelined)
        |-> flash_rate_ok == (flash_pipelined ? CLK_MHZ <= 160 : CLK_MHZ <= 36))
        else $error("flash rate flag wrong for mode");
endmodule // system_memory_map_decoder

// >>> sim/flash_array_model.sv
// Flash array model answering fetch requests
`timescale 1ns/1ps
module flash_array_model (
    // Clock
    input  wire logic         clk,
    // Fetch
    input  wire logic         flash_fetch_req,
    input  wire logic [20:0]  flash_fetch_addr,
    input  wire logic [3:0]   wait_cycles,
    output logic              flash_fetch_valid,
    output logic [127:0]      flash_fetch_data
);
    logic [3:0] cnt_reg;
    // No check bits are modelled, so every word reads back clean
    // Data inverts when not valid, so a stale word never passes for a fresh one
    always_ff @(posedge clk) begin
        flash_fetch_valid <= 1'b0;
        flash_fetch_data  <= ~flash_fetch_data;
        cnt_reg           <= flash_fetch_req ? cnt_reg + 4'h1 : 4'h0;
        if (flash_fetch_req && !flash_fetch_valid && cnt_reg >= wait_cycles) begin
            flash_fetch_valid <= 1'b1;
            flash_fetch_data  <= {11'h0, flash_fetch_addr, 11'h1, flash_fetch_addr,
                                  11'h2, flash_fetch_addr, 11'h3, flash_fetch_addr};
            cnt_reg           <= 4'h0;
        end
    end
endmodule // flash_array_model

// >>> sim/system_memory_map_decoder_bench.sv
// Bench for the system memory map decoder
`timescale 1ns/1ps
`include "memmap_defines.svh"
module system_memory_map_decoder_bench;
logic clk, resetn, read_mode_we, ext_width_we, ext_width_8_in, overlay_redirect, req_valid;
logic req_ready, resp_valid, resp_last, resp_error, flash_fetch_req, flash_fetch_wide;
logic flash_fetch_valid, flash_prog_req, flash_prog_half, flash_erase_req;
logic flash_pipelined, flash_rate_ok, ext_width_8;
logic [2:0] read_mode_in, flash_read_control;
logic [31:0] req_addr, resp_offset;
memmap_pkg::cmd_t req_cmd;
memmap_pkg::size_t req_size;
logic [`TGT_W-1:0] resp_target;
logic [1:0] resp_ext_cs, flash_erase_bank;
logic [3:0] flash_erase_sector, wait_cycles;
logic [63:0] resp_data;
logic [20:0] flash_fetch_addr, flash_prog_addr, flash_erase_base;
logic [127:0] flash_fetch_data;
int n_errors, checked, k, w, a, b, s, bs;
int fb[10] = '{'hFFA00000, 'hFFA01000, 'hFFA02000, 'hFFA03000, 'hFFA04000,
               'hFFF80000, 'hFFF87000, 'hFFFFE000, 'hFFFFF500, 'hFFFFFC00};
// Rate check needs a clock between the two flash limits
system_memory_map_decoder #(.CLK_MHZ(100)) system_memory_map_decoder_i (.*);
flash_array_model flash_array_model_i (.*);
task automatic tally_and_finish;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
task automatic chk(input string n, input logic [71:0] v, input logic [71:0] e);
    checked++;
    if (v !== e) begin
        n_errors++;
        $display("[ERR] %s exp %h seen %h", n, e, v);
    end
endtask
task automatic step;
    @(posedge clk);
    #1;
endtask
task automatic acc(input int ad, input int c, input int z);
    int i;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) step;
    if (i == 20) begin
        n_errors++;
        tally_and_finish;
    end
    req_addr = ad;
    req_cmd = memmap_pkg::cmd_t'(c);
    req_size = memmap_pkg::size_t'(z);
    req_valid = 1'b1;
    step;
    req_valid = 1'b0;
    for (i = 0; i < 40 && resp_valid !== 1'b1; i++) step;
    if (i == 40) begin
        n_errors++;
        tally_and_finish;
    end
endtask
task automatic cfg(input logic m, input logic [2:0] v);
    {read_mode_we, ext_width_we, read_mode_in, ext_width_8_in} = {!m, m, v, v[0]};
    step;
    {read_mode_we, ext_width_we} = 2'b00;
    step;
endtask
function automatic logic [63:0] pat(input logic [20:0] f, input logic [10:0] h);
    return {h, f, h + 11'h1, f};
endfunction
function automatic void sec(input int a, output int b, output int s, output int bs);
    {b, s, bs} = {a >> 19, (a >> 17) & 3, a & 'h1E0000};
    if (b != 0) return;
    if (a < 'h18000) {s, bs} = {a >> 15, a & 'h18000};
    else if (a < 'h1C000) {s, bs} = {3 + ((a - 'h18000) >> 13), a & 'h1E000};
    else if (a < 'h20000) {s, bs} = {5, 'h1C000};
    else if (a < 'h40000) {s, bs} = {4 + (a >> 16), a & 'h30000};
    else {s, bs} = {6 + (a >> 17), a & 'h60000};
endfunction
initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
initial begin
    {resetn, read_mode_we, ext_width_we, ext_width_8_in, overlay_redirect, req_valid} = '0;
    {read_mode_in, req_addr, wait_cycles, n_errors, checked} = '0;
    req_cmd = memmap_pkg::CMD_READ;
    req_size = memmap_pkg::SZ_WORD;
    void'($urandom(32'hB0E1C879));
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    chk("rst", {flash_read_control, ext_width_8, flash_rate_ok}, 0);
    for (k = 0; k < 10; k++) begin
        s = k < 7 ? 'h1000 : 'h100;
        a = fb[k] + $urandom % s;
        acc(a, 0, 2);
        chk("frame", {resp_error, resp_target, resp_offset}, {1 << (k + 2), a & 'hFFF});
        if (k > 3) acc(fb[k] + s, 1, 2);
        if (k > 3) chk("miss", {resp_error, resp_target}, 1 << `TGT_W);
    end
    for (w = 0; w < 2; w++) begin
        cfg(1, w);
        for (k = 0; k < 4; k++) begin
            s = w ? 'h100_0000 : 'h200_0000;
            acc(`EXT_BASE + k * `EXT_CS_SPAN + s - 1, 0, 2);
            chk("ext", {resp_error, resp_target[1], resp_ext_cs, resp_offset}, {2'b01, k[1:0], s - 1});
            acc(`EXT_BASE + k * `EXT_CS_SPAN + s, 0, 2);
            chk("lim", {ext_width_8, resp_error}, {w[0], 1'b1});
        end
    end
    acc(`OVL_BASE + 'h3F_FFFF, 0, 2);
    chk("ovl", {resp_error, resp_target[1], resp_ext_cs, resp_offset}, {4'h4, 32'h3F_FFFF});
    overlay_redirect = 1'b1;
    acc('h12344, 0, 2);
    chk("redir", {resp_target[1], resp_ext_cs, resp_offset}, {3'h4, 32'h12344});
    overlay_redirect = 1'b0;
    for (w = 1; w >= 0; w--) begin
        cfg(0, w);
        chk("mode", {flash_read_control, flash_pipelined, flash_rate_ok}, {w[2:0], w[0], w[0]});
        for (k = 0; k < 6; k++) begin
            wait_cycles = $urandom;
            a = $urandom % 'h20_0000;
            b = w ? a & ~15 : a & ~7;
            acc(a, 0, 3);
            chk("beat", {resp_last, flash_fetch_wide, resp_data},
                w ? {2'b01, pat(b, 0)} : {2'b10, pat(b, 2)});
            if (w) step;
            if (w) chk("beat2", {resp_valid, resp_last, resp_data}, {2'b11, pat(b, 2)});
        end
    end
    for (k = 0; k < 4; k++) begin
        a = $urandom % 'h20_0000 & ~3;
        s = k == 1 || k == 2;
        acc(a, 2, k);
        chk("prog", {resp_error, flash_prog_req}, {!s[0], s[0]});
        if (s) chk("pdat", {flash_prog_half, flash_prog_addr}, {k == 1, a[20:0]});
    end
    for (k = 0; k < 12; k++) begin
        a = k == 0 ? 'h1C123 : k == 1 ? 'h18_4000 : k == 2 ? 'h1A010 :
            $urandom % (k < 8 ? 'h8_0000 : 'h20_0000);
        sec(a, b, s, bs);
        acc(a, 3, 2);
        chk("erase", {flash_erase_req, flash_erase_bank, flash_erase_sector, flash_erase_base}, {1'b1, b[1:0], s[3:0], bs[20:0]});
    end
    acc('h20_0000, 0, 2);
    chk("top", resp_error, 1);
    tally_and_finish;
end
endmodule // system_memory_map_decoder_bench
